/* rtl/cgh_defs.svh */
// Register offsets, field positions, reset values and scale constants
`ifndef CGH_DEFS_SVH
`define CGH_DEFS_SVH

`define CGH_ADDR_W 12
`define CGH_OFS_CTRL 12'h02c
`define CGH_OFS_U_LOW 12'h034
`define CGH_OFS_V_LOW 12'h038
`define CGH_OFS_HUE 12'h03c
`define CGH_OFS_STATUS 12'h0f0

`define CGH_RST_CTRL 8'h20
`define CGH_RST_U_LOW 8'hfe
`define CGH_RST_V_LOW 8'hb4
`define CGH_RST_HUE 8'h00

`define CGH_BIT_U_TOP 1
`define CGH_BIT_V_TOP 0
`define CGH_BIT_U_CLIP 0
`define CGH_BIT_V_CLIP 1

// Unity gain codes and their 2^16 reciprocals
`define CGH_U_UNITY 9'h0fe
`define CGH_V_UNITY 9'h0b4
`define CGH_U_RECIP 10'h102
`define CGH_V_RECIP 10'h16c
`define CGH_SCALE_SHIFT 16
`define CGH_ROUND 28'h0008000

// Hue code to phase: one code is 1/512 turn of a 16-bit phase
`define CGH_PHASE_W 16
`define CGH_HUE_SHIFT 7
`define CGH_HUE_MINUS_90 16'hc000

`endif

/* rtl/cgh_gain_mul.sv */
// One colour-difference gain multiplier with saturation
`timescale 1ns/100ps
`include "cgh_defs.svh"
module cgh_gain_mul #(
    parameter logic [9:0] RECIP = `CGH_U_RECIP
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire cgh_pkg::cgh_sample_t i_sample,
    input wire logic [8:0] i_gain,
    output cgh_pkg::cgh_sample_t o_sample,
    output logic o_clip
);
    wire logic signed [27:0] ext_sample = 28'(i_sample);
    wire logic signed [27:0] ext_gain = 28'($signed({1'b0, i_gain}));
    wire logic signed [27:0] ext_recip = 28'($signed({1'b0, RECIP}));
    wire logic signed [27:0] product = ext_sample * ext_gain * ext_recip;
    wire logic signed [27:0] rounded = product + $signed(`CGH_ROUND);
    wire logic signed [27:0] scaled = rounded >>> `CGH_SCALE_SHIFT;
    wire logic too_high = scaled > 28'sd127;
    wire logic too_low = scaled < -28'sd128;
    // Clamp instead of wrapping
    wire cgh_pkg::cgh_sample_t clamped = too_high ? 8'sh7f :
        too_low ? 8'sh80 : scaled[7:0];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sample <= 8'sh00;
            o_clip <= 1'b0;
        end else if (i_valid) begin
            o_sample <= clamped;
            o_clip <= too_high | too_low;
        end else begin
            o_clip <= 1'b0;
        end
    end
endmodule

/* rtl/cgh_pkg.sv */
// Types shared by the chroma gain and hue stage
package cgh_pkg;
    typedef enum logic [1:0] {
        CGH_STD_NTSC = 2'b00,
        CGH_STD_PAL = 2'b01,
        CGH_STD_SECAM = 2'b10,
        CGH_STD_DIGITAL = 2'b11
    } cgh_std_t;
    typedef logic signed [7:0] cgh_sample_t;
endpackage

/* rtl/cgh_top.sv */
// Chroma gain and hue stage with its APB register file
//
// What this block and its software do
// RULE1: U gain is control bit plus U low byte
// RULE2: U scaled by gain, 254 is unity
// RULE3: V gain is control bit plus V low byte
// RULE4: V scaled by gain, 180 is unity
// RULE5: Software keeps U to V ratio fixed
// RULE6: Software read-modify-writes the control register
// RULE7: Signed hue added to subcarrier phase
// RULE8: 256 hue steps of 0.7 degree
// RULE9: Hue register resets to zero
// RULE10: No hue offset for PAL, SECAM, digital
// RULE11: U top bit is control bit 1
// RULE12: V top bit is control bit 0
// RULE13: Gain products saturate, never wrap
`timescale 1ns/100ps
`include "cgh_defs.svh"
module cgh_top (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [`CGH_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire cgh_pkg::cgh_std_t I_STD,
    input wire logic [`CGH_PHASE_W-1:0] I_SC_PHASE,
    input wire logic I_VALID,
    input wire cgh_pkg::cgh_sample_t I_U,
    input wire cgh_pkg::cgh_sample_t I_V,
    output logic O_VALID,
    output cgh_pkg::cgh_sample_t O_U,
    output cgh_pkg::cgh_sample_t O_V,
    output logic [`CGH_PHASE_W-1:0] O_SC_PHASE
);
    logic [7:0] ctrl;
    logic [7:0] chroma_u_gain_low;
    logic [7:0] chroma_v_gain_low;
    logic [7:0] hue_phase_offset;
    logic [1:0] clip_flags;
    logic [31:0] rdata;
    logic u_clip;
    logic v_clip;

    // Bus decode
    wire logic hit_ctrl = I_PADDR == `CGH_OFS_CTRL;
    wire logic hit_u = I_PADDR == `CGH_OFS_U_LOW;
    wire logic hit_v = I_PADDR == `CGH_OFS_V_LOW;
    wire logic hit_hue = I_PADDR == `CGH_OFS_HUE;
    wire logic hit_status = I_PADDR == `CGH_OFS_STATUS;
    wire logic mapped = hit_ctrl | hit_u | hit_v | hit_hue | hit_status;
    wire logic setup = I_PSEL & ~I_PENABLE;
    wire logic access = I_PSEL & I_PENABLE;
    wire logic wr_low = access & I_PWRITE & I_PSTRB[0] & mapped;
    wire logic [7:0] wbyte = I_PWDATA[7:0];

    // Gain words formed from control top bits and low bytes
    wire logic chroma_u_gain_top_bit = ctrl[`CGH_BIT_U_TOP]; // RULE11
    wire logic chroma_v_gain_top_bit = ctrl[`CGH_BIT_V_TOP]; // RULE12
    wire logic [8:0] chroma_u_gain_word =
        {chroma_u_gain_top_bit, chroma_u_gain_low}; // RULE1
    wire logic [8:0] chroma_v_gain_word =
        {chroma_v_gain_top_bit, chroma_v_gain_low}; // RULE3

    // Hue applies only to the remaining analogue standard
    wire logic hue_active = I_STD == cgh_pkg::CGH_STD_NTSC; // RULE10
    wire logic [`CGH_PHASE_W-1:0] hue_step = {
        {(`CGH_PHASE_W-8-`CGH_HUE_SHIFT){hue_phase_offset[7]}},
        hue_phase_offset, {`CGH_HUE_SHIFT{1'b0}}}; // RULE7 RULE8
    wire logic [`CGH_PHASE_W-1:0] next_phase = hue_active ?
        I_SC_PHASE + hue_step : I_SC_PHASE; // RULE7 RULE10

    wire logic [1:0] next_clip_flags = ({v_clip, u_clip}) |
        (clip_flags & ~((wr_low & hit_status) ? wbyte[1:0] : 2'b00));

    wire logic [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl} :
        hit_u ? {24'h0, chroma_u_gain_low} :
        hit_v ? {24'h0, chroma_v_gain_low} :
        hit_hue ? {24'h0, hue_phase_offset} :
        hit_status ? {30'h0, clip_flags} : 32'h0;

    assign O_PREADY = 1'b1;
    assign O_PSLVERR = access & ~mapped;
    assign O_PRDATA = rdata;

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl <= `CGH_RST_CTRL; // RULE11 RULE12
            chroma_u_gain_low <= `CGH_RST_U_LOW; // RULE1
            chroma_v_gain_low <= `CGH_RST_V_LOW; // RULE3
            hue_phase_offset <= `CGH_RST_HUE; // RULE9
        end else if (wr_low) begin
            if (hit_ctrl) begin
                ctrl <= wbyte;
            end
            if (hit_u) begin
                chroma_u_gain_low <= wbyte;
            end
            if (hit_v) begin
                chroma_v_gain_low <= wbyte;
            end
            if (hit_hue) begin
                hue_phase_offset <= wbyte;
            end
        end
    end

    // Clip flags are sticky; a new clip beats a write-one clear
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            clip_flags <= 2'b00;
        end else begin
            clip_flags <= next_clip_flags; // RULE13
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata <= 32'h0;
        end else if (setup) begin
            rdata <= rd_mux;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_VALID <= 1'b0;
            O_SC_PHASE <= '0;
        end else begin
            O_VALID <= I_VALID;
            O_SC_PHASE <= next_phase;
        end
    end

    cgh_gain_mul #(
        .RECIP(`CGH_U_RECIP)
    ) u_gain (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_valid(I_VALID),
        .i_sample(I_U),
        .i_gain(chroma_u_gain_word),
        .o_sample(O_U),
        .o_clip(u_clip)
    ); // RULE2 RULE13

    cgh_gain_mul #(
        .RECIP(`CGH_V_RECIP)
    ) v_gain (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_valid(I_VALID),
        .i_sample(I_V),
        .i_gain(chroma_v_gain_word),
        .o_sample(O_V),
        .o_clip(v_clip)
    ); // RULE4 RULE13

    // Helper state for the checks below
    logic hue_written;
    logic ctrl_written;
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            hue_written <= 1'b0;
            ctrl_written <= 1'b0;
        end else begin
            hue_written <= hue_written | (wr_low & hit_hue);
            ctrl_written <= ctrl_written | (wr_low & hit_ctrl);
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    AST_U_WORD_WRITE: assert property ( // RULE1
        wr_low && hit_u |=> chroma_u_gain_word ==
            {$past(ctrl[`CGH_BIT_U_TOP]), $past(wbyte)})
    else $error("U gain word not updated from write");

    AST_U_UNITY: assert property ( // RULE2
        I_VALID && chroma_u_gain_word == `CGH_U_UNITY |=>
            O_U == $past(I_U))
    else $error("U unity gain altered the sample");

    AST_U_ZERO: assert property ( // RULE2
        I_VALID && chroma_u_gain_word == 9'h000 |=> O_U == 8'sh00)
    else $error("U zero gain left a sample");

    AST_V_WORD_WRITE: assert property ( // RULE3
        wr_low && hit_v |=> chroma_v_gain_word ==
            {$past(ctrl[`CGH_BIT_V_TOP]), $past(wbyte)})
    else $error("V gain word not updated from write");

    AST_V_UNITY: assert property ( // RULE4
        I_VALID && chroma_v_gain_word == `CGH_V_UNITY |=>
            O_V == $past(I_V))
    else $error("V unity gain altered the sample");

    AST_V_ZERO: assert property ( // RULE4
        I_VALID && chroma_v_gain_word == 9'h000 |=> O_V == 8'sh00)
    else $error("V zero gain left a sample");

    AST_HUE_ADD: assert property ( // RULE7
        hue_active && hue_phase_offset == 8'h01 |=>
            O_SC_PHASE == $past(I_SC_PHASE) + 16'h0080)
    else $error("Hue step not added to subcarrier phase");

    AST_HUE_MIN: assert property ( // RULE8
        hue_active && hue_phase_offset == 8'h80 |=>
            O_SC_PHASE == $past(I_SC_PHASE) + `CGH_HUE_MINUS_90)
    else $error("Hue code 0x80 is not a quarter turn back");

    AST_HUE_RESET: assert property ( // RULE9
        !hue_written |-> hue_phase_offset == 8'h00)
    else $error("Hue offset present before any hue write");

    AST_HUE_RESET_PHASE: assert property ( // RULE9
        !hue_written && hue_active |=> O_SC_PHASE == $past(I_SC_PHASE))
    else $error("Phase moved before any hue write");

    AST_HUE_MAX: assert property ( // RULE8
        hue_active && hue_phase_offset == 8'h7f |=>
            O_SC_PHASE == $past(I_SC_PHASE) + 16'h3f80)
    else $error("Hue code 0x7f is not the top step");

    AST_HUE_BYPASS: assert property ( // RULE10
        !hue_active |=> O_SC_PHASE == $past(I_SC_PHASE))
    else $error("Hue applied outside the analogue standard");

    AST_U_TOP_RESET: assert property ( // RULE11
        !ctrl_written |-> chroma_u_gain_word[8] == 1'b0)
    else $error("U top bit set without a control write");

    AST_V_TOP_RESET: assert property ( // RULE12
        !ctrl_written |-> chroma_v_gain_word[8] == 1'b0)
    else $error("V top bit set without a control write");

    AST_U_TOP_WRITE: assert property ( // RULE11
        wr_low && hit_ctrl |=> chroma_u_gain_word[8] == $past(wbyte[1]))
    else $error("U top bit not taken from control bit 1");

    AST_V_TOP_WRITE: assert property ( // RULE12
        wr_low && hit_ctrl |=> chroma_v_gain_word[8] == $past(wbyte[0]))
    else $error("V top bit not taken from control bit 0");

    // Wrap is only possible above unity, so small gains are left out
    AST_U_NO_WRAP: assert property ( // RULE13
        I_VALID && I_U > 8'sh00 && chroma_u_gain_word >= `CGH_U_UNITY |=>
            O_U > 8'sh00)
    else $error("Positive U sample wrapped negative");

    AST_V_NO_WRAP: assert property ( // RULE13
        I_VALID && I_V < 8'sh00 && chroma_v_gain_word >= `CGH_V_UNITY |=>
            O_V < 8'sh00)
    else $error("Negative V sample wrapped positive");

    AST_U_SATURATE: assert property ( // RULE13
        I_VALID && I_U >= 8'sh40 && chroma_u_gain_word >= 9'h1fc |=>
            O_U == 8'sh7f)
    else $error("Large U product not clamped to the top");

    AST_V_SATURATE: assert property ( // RULE13
        I_VALID && I_V <= 8'shc0 && chroma_v_gain_word >= 9'h168 |=>
            O_V == 8'sh80)
    else $error("Large V product not clamped to the bottom");

    AST_CLIP_STICKY: assert property ( // RULE13
        clip_flags[`CGH_BIT_U_CLIP] && !(wr_low && hit_status) |=>
            clip_flags[`CGH_BIT_U_CLIP])
    else $error("U clip flag dropped without a clear");

    AST_CLIP_SET_WINS: assert property ( // RULE13
        u_clip |=> clip_flags[`CGH_BIT_U_CLIP])
    else $error("U clip event lost");

    AST_V_CLIP_STICKY: assert property ( // RULE13
        clip_flags[`CGH_BIT_V_CLIP] && !(wr_low && hit_status) |=>
            clip_flags[`CGH_BIT_V_CLIP])
    else $error("V clip flag dropped without a clear");

    AST_V_CLIP_SET_WINS: assert property ( // RULE13
        v_clip |=> clip_flags[`CGH_BIT_V_CLIP])
    else $error("V clip event lost");

    AST_CLIP_CLEAR: assert property ( // RULE13
        wr_low && hit_status && wbyte[0] && !u_clip |=>
            !clip_flags[`CGH_BIT_U_CLIP])
    else $error("U clip flag not cleared by a one");

    AST_V_CLIP_CLEAR: assert property ( // RULE13
        wr_low && hit_status && wbyte[1] && !v_clip |=>
            !clip_flags[`CGH_BIT_V_CLIP])
    else $error("V clip flag not cleared by a one");

    AST_RD_DATA: assert property (
        setup && hit_hue ##1 access |-> O_PRDATA ==
            {24'h0, $past(hue_phase_offset)})
    else $error("Hue read returned wrong data");

endmodule

/* verification/tb.sv */
// Self-checking bench for the chroma gain and hue stage
`timescale 1ns/100ps
`include "cgh_defs.svh"
module tb;
    typedef struct {
        logic [8:0] ug;
        logic [8:0] vg;
        logic [7:0] hue;
        cgh_pkg::cgh_std_t std;
        logic [7:0] u;
        logic [7:0] v;
        logic [7:0] eu;
        logic [7:0] ev;
        logic [15:0] ph;
        logic [15:0] eph;
    } cgh_row_t;
    logic I_CLK = 1'b0;
    logic I_RESET_N = 1'b0;
    logic I_PSEL = 1'b0;
    logic I_PENABLE = 1'b0;
    logic I_PWRITE = 1'b0;
    logic [11:0] I_PADDR = 12'h000;
    logic [31:0] I_PWDATA = 32'h0;
    logic [3:0] I_PSTRB = 4'h0;
    logic [31:0] O_PRDATA;
    logic O_PREADY;
    logic O_PSLVERR;
    cgh_pkg::cgh_std_t I_STD = cgh_pkg::CGH_STD_NTSC;
    logic [15:0] I_SC_PHASE = 16'h0;
    logic I_VALID = 1'b0;
    cgh_pkg::cgh_sample_t I_U = 8'h00;
    cgh_pkg::cgh_sample_t I_V = 8'h00;
    logic O_VALID;
    cgh_pkg::cgh_sample_t O_U;
    cgh_pkg::cgh_sample_t O_V;
    logic [15:0] O_SC_PHASE;
    int err_count = 0;
    int n_checks = 0;
    cgh_row_t rows [7];
    logic [31:0] rd;
    logic er;
    cgh_top i_cgh_top (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
        .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
        .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
        .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
        .I_STD(I_STD), .I_SC_PHASE(I_SC_PHASE), .I_VALID(I_VALID),
        .I_U(I_U), .I_V(I_V), .O_VALID(O_VALID), .O_U(O_U), .O_V(O_V),
        .O_SC_PHASE(O_SC_PHASE));
    always #10 I_CLK = ~I_CLK;
    task give_verdict;
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready under a bound
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int k;
        I_PSEL <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PWRITE <= wr;
        I_PADDR <= a;
        I_PWDATA <= d;
        I_PSTRB <= s;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge I_CLK);
            k++;
        end while (O_PREADY !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_count++;
            $display("[ERR] %0t no pready", $time);
            give_verdict();
        end
        rd = O_PRDATA;
        er = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
        @(posedge I_CLK);
    endtask
    // Present one sample, then check the registered result
    task send(input cgh_row_t r);
        I_VALID <= 1'b1;
        I_U <= r.u;
        I_V <= r.v;
        I_STD <= r.std;
        I_SC_PHASE <= r.ph;
        @(posedge I_CLK);
        I_VALID <= 1'b0;
        @(negedge I_CLK);
        chk({31'h0, O_VALID}, 32'h1);
        chk({24'h0, O_U}, {24'h0, r.eu});
        chk({24'h0, O_V}, {24'h0, r.ev});
        chk({16'h0, O_SC_PHASE}, {16'h0, r.eph});
        @(posedge I_CLK);
    endtask
    initial begin
        rows = '{
            '{9'h0fe, 9'h0b4, 8'h00, cgh_pkg::CGH_STD_NTSC,
                8'h0a, 8'hec, 8'h0a, 8'hec, 16'h1234, 16'h1234},
            '{9'h000, 9'h000, 8'h80, cgh_pkg::CGH_STD_NTSC,
                8'h64, 8'h9c, 8'h00, 8'h00, 16'h1000, 16'hd000},
            '{9'h1ff, 9'h1ff, 8'h7f, cgh_pkg::CGH_STD_PAL,
                8'h64, 8'h9c, 8'h7f, 8'h80, 16'h5555, 16'h5555},
            '{9'h1fc, 9'h168, 8'h01, cgh_pkg::CGH_STD_SECAM,
                8'h32, 8'hce, 8'h64, 8'h9c, 16'h0abc, 16'h0abc},
            '{9'h07f, 9'h05a, 8'h80, cgh_pkg::CGH_STD_DIGITAL,
                8'hc0, 8'h40, 8'he0, 8'h20, 16'h7777, 16'h7777},
            '{9'h0fe, 9'h0b4, 8'h01, cgh_pkg::CGH_STD_NTSC,
                8'h80, 8'h7f, 8'h80, 8'h7f, 16'hff80, 16'h0000},
            '{9'h0fe, 9'h0b4, 8'h7f, cgh_pkg::CGH_STD_NTSC,
                8'h80, 8'h7f, 8'h80, 8'h7f, 16'hf000, 16'h2f80}};
        repeat (4) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        @(posedge I_CLK);
        foreach (rows[i]) begin
            apb(1'b0, `CGH_OFS_CTRL, 32'h0, 4'h0);
            apb(1'b1, `CGH_OFS_CTRL,
                {rd[31:2], rows[i].ug[8], rows[i].vg[8]}, 4'hf);
            apb(1'b1, `CGH_OFS_U_LOW, {24'h0, rows[i].ug[7:0]}, 4'hf);
            apb(1'b1, `CGH_OFS_V_LOW, {24'h0, rows[i].vg[7:0]}, 4'hf);
            apb(1'b1, `CGH_OFS_HUE, {24'h0, rows[i].hue}, 4'hf);
            apb(1'b0, `CGH_OFS_CTRL, 32'h0, 4'h0);
            chk(rd, {24'h0, 6'h08, rows[i].ug[8], rows[i].vg[8]});
            send(rows[i]);
        end
        @(negedge I_CLK);
        chk({24'h0, O_U}, 32'h80);
        @(posedge I_CLK);
        apb(1'b0, `CGH_OFS_STATUS, 32'h0, 4'h0);
        chk(rd, 32'h3);
        chk({31'h0, er}, 32'h0);
        apb(1'b1, `CGH_OFS_STATUS, 32'h1, 4'hf);
        apb(1'b0, `CGH_OFS_STATUS, 32'h0, 4'h0);
        chk(rd, 32'h2);
        apb(1'b1, `CGH_OFS_STATUS, 32'h2, 4'hf);
        apb(1'b0, `CGH_OFS_STATUS, 32'h0, 4'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h040, 32'h0, 4'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `CGH_OFS_HUE, 32'h55, 4'h0);
        apb(1'b0, `CGH_OFS_HUE, 32'h0, 4'h0);
        chk(rd, 32'h7f);
        apb(1'b1, `CGH_OFS_U_LOW, 32'habcd12, 4'hf);
        apb(1'b0, `CGH_OFS_U_LOW, 32'h0, 4'h0);
        chk(rd, 32'h12);
        I_RESET_N <= 1'b0;
        repeat (2) @(posedge I_CLK);
        I_RESET_N <= 1'b1;
        @(posedge I_CLK);
        apb(1'b0, `CGH_OFS_U_LOW, 32'h0, 4'h0);
        chk(rd, 32'hfe);
        apb(1'b0, `CGH_OFS_V_LOW, 32'h0, 4'h0);
        chk(rd, 32'hb4);
        apb(1'b0, `CGH_OFS_HUE, 32'h0, 4'h0);
        chk(rd, 32'h00);
        apb(1'b0, `CGH_OFS_CTRL, 32'h0, 4'h0);
        chk(rd, 32'h20);
        send(rows[0]);
        give_verdict();
    end
endmodule
